//--- rtl/fsfl_pkg.sv
// Package for the status-flag logic: instruction classes, status word layout
package fsfl_pkg;

  // Status word bit positions
  localparam int unsigned FSFL_EXC_LSB = 0;
  localparam int unsigned FSFL_EXC_W = 6;
  localparam int unsigned FSFL_SF_BIT = 6;
  localparam int unsigned FSFL_ES_BIT = 7;
  localparam int unsigned FSFL_C0_BIT = 8;
  localparam int unsigned FSFL_C1_BIT = 9;
  localparam int unsigned FSFL_C2_BIT = 10;
  localparam int unsigned FSFL_TOP_LSB = 11;
  localparam int unsigned FSFL_C3_BIT = 14;
  localparam int unsigned FSFL_B_BIT = 15;
  localparam int unsigned FSFL_IE_IDX = 0;
  localparam int unsigned FSFL_PE_IDX = 5;

  // Values after reset and initialize
  localparam logic [5:0] FSFL_EXC_RST = 6'h00;
  localparam logic [3:0] FSFL_CC_RST = 4'h0;
  localparam logic [2:0] FSFL_TOP_RST = 3'h0;
  localparam logic [5:0] FSFL_MASK_RST = 6'h3F;

  // Compare result codes as {c3, c2, c0}
  localparam logic [2:0] FSFL_CMP_GT = 3'h0;
  localparam logic [2:0] FSFL_CMP_LT = 3'h1;
  localparam logic [2:0] FSFL_CMP_EQ = 3'h4;
  localparam logic [2:0] FSFL_CMP_UN = 3'h7;

  typedef enum logic [3:0] {
    FSFL_OP_NONE,
    FSFL_OP_COMPARE,
    FSFL_OP_EXAMINE,
    FSFL_OP_PREM,
    FSFL_OP_TRIG,
    FSFL_OP_ARITH,
    FSFL_OP_MOVE,
    FSFL_OP_ENV_LOAD,
    FSFL_OP_INIT,
    FSFL_OP_CLEAR_EXC,
    FSFL_OP_UNDEF_CC,
    FSFL_OP_SET_MASK
  } fsfl_op_t;

  typedef enum logic [1:0] {
    FSFL_CMP_R_GT,
    FSFL_CMP_R_LT,
    FSFL_CMP_R_EQ,
    FSFL_CMP_R_UN
  } fsfl_cmp_t;

  // One retiring instruction and its outcome
  typedef struct packed {
    logic valid;
    fsfl_op_t op;
    logic [5:0] exc;
    logic stack_fault;
    logic stack_overflow;
    logic round_up;
    logic sign;
    logic [2:0] operand_class;
    fsfl_cmp_t cmp;
    logic reduction_incomplete;
    logic [2:0] quotient;
    logic out_of_range;
    logic [2:0] top;
    logic [15:0] image;
  } fsfl_instr_t;

endpackage

//--- rtl/fsfl_status.sv
// Status word update logic of a floating-point stack unit
`timescale 1ns/100ps
// Functional notes
// [RULE1] Stack fault: cond_bit_one 1 overflow, 0 underflow
// [RULE2] Inexact result: cond_bit_one shows round-up
// [RULE3] Examine: cond_bit_one sign, others class
// [RULE4] Partial remainder: cond_bit_two shows incomplete
// [RULE5] Complete remainder: quotient into c0, c3, c1
// [RULE6] Trig: cond_bit_two flags source out of range
// [RULE7] Trig: c0,c3 undefined; c1 undefined if c2
// [RULE8] Compare encodes result in c0,c3,c2
// [RULE9] Arithmetic class: c1 round-up or stack fault
// [RULE10] Move class: c1 cleared unless stack fault
// [RULE11] Env load loads cc; init clears cc
// [RULE12] Control-type ops leave cc undefined
// [RULE13] Six sticky exception flags in bits 0-5
// [RULE14] Summary bit 7 set by unmasked flags only
// [RULE15] Summary set raises exception request output
// [RULE16] Flags held until clear, init or load
// [RULE17] Bit 15 mirrors exception summary
// [RULE18] Stack fault flag bit 6 on stack fault
// [RULE19] Invalid operand alone never clears stack fault
// [RULE20] Stack fault held until init, clear, load
// [RULE21] Top pointer in bits 11-13
// [RULE22] Control mask bits gate summary per flag
// [RULE23] Compare: gt 000, lt 001, eq 100, un 111
module fsfl_status
  import fsfl_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Retiring instruction
  input wire fsfl_pkg::fsfl_instr_t instr_i,
  // Status word and exception request
  output logic [15:0] status_word_o,
  output logic fp_exception_o
);
  import fsfl_pkg::*;

  logic [5:0] exc_ff;
  logic [5:0] nxt_exc;
  logic [5:0] mask_ff;
  logic [5:0] nxt_mask;
  logic sf_ff;
  logic nxt_sf;
  logic [3:0] cc_ff;
  logic [3:0] nxt_cc;
  logic [2:0] top_ff;
  logic [2:0] nxt_top;
  logic req_ff;

  wire logic v = instr_i.valid;
  wire fsfl_op_t op = instr_i.op;
  wire logic is_load = v && op == FSFL_OP_ENV_LOAD;
  wire logic is_init = v && op == FSFL_OP_INIT;
  wire logic is_clr = v && op == FSFL_OP_CLEAR_EXC;
  wire logic is_mask = v && op == FSFL_OP_SET_MASK;
  wire logic evt = v && !is_load && !is_init && !is_clr && !is_mask;
  wire logic fault = evt && instr_i.stack_fault;
  wire logic inexact = instr_i.exc[FSFL_PE_IDX];
  wire logic summary = |(exc_ff & ~mask_ff);

  // Compare code as {c3, c2, c0}
  function automatic logic [2:0] cmp_code(input fsfl_cmp_t r);
    case (r)
      FSFL_CMP_R_GT: cmp_code = FSFL_CMP_GT;
      FSFL_CMP_R_LT: cmp_code = FSFL_CMP_LT;
      FSFL_CMP_R_EQ: cmp_code = FSFL_CMP_EQ;
      default: cmp_code = FSFL_CMP_UN;
    endcase
  endfunction

  // Stack fault direction wins over round-up in cond_bit_one
  wire logic c1_round = fault ? instr_i.stack_overflow : // [RULE1]
                        (inexact && instr_i.round_up); // [RULE2] [RULE9]
  wire logic c1_move = fault && instr_i.stack_overflow; // [RULE10]
  wire logic [2:0] cmp_bits = cmp_code(instr_i.cmp); // [RULE23]

  // Undefined condition bits keep their old value, so nothing changes
  // that software must not read anyway.
  always_comb
  begin
    nxt_cc = cc_ff;
    if (v)
    begin
      case (op)
        FSFL_OP_COMPARE:
        begin
          nxt_cc[3] = cmp_bits[2]; // [RULE8]
          nxt_cc[2] = cmp_bits[1];
          nxt_cc[0] = cmp_bits[0];
          nxt_cc[1] = c1_move;
        end
        FSFL_OP_EXAMINE:
        begin
          nxt_cc[1] = instr_i.sign; // [RULE3]
          nxt_cc[3] = instr_i.operand_class[2];
          nxt_cc[2] = instr_i.operand_class[1];
          nxt_cc[0] = instr_i.operand_class[0];
        end
        FSFL_OP_PREM:
        begin
          nxt_cc[2] = instr_i.reduction_incomplete; // [RULE4]
          if (!instr_i.reduction_incomplete)
          begin
            nxt_cc[0] = instr_i.quotient[2]; // [RULE5]
            nxt_cc[3] = instr_i.quotient[1];
            nxt_cc[1] = instr_i.quotient[0];
          end
          else if (fault)
            nxt_cc[1] = instr_i.stack_overflow;
        end
        FSFL_OP_TRIG:
        begin
          nxt_cc[2] = instr_i.out_of_range; // [RULE6]
          if (!instr_i.out_of_range)
            nxt_cc[1] = c1_round; // [RULE7]
        end
        FSFL_OP_ARITH: nxt_cc[1] = c1_round; // [RULE9]
        FSFL_OP_MOVE: nxt_cc[1] = c1_move; // [RULE10]
        FSFL_OP_ENV_LOAD:
        begin
          nxt_cc[0] = instr_i.image[FSFL_C0_BIT]; // [RULE11]
          nxt_cc[1] = instr_i.image[FSFL_C1_BIT];
          nxt_cc[2] = instr_i.image[FSFL_C2_BIT];
          nxt_cc[3] = instr_i.image[FSFL_C3_BIT];
        end
        FSFL_OP_INIT: nxt_cc = FSFL_CC_RST; // [RULE11]
        default: nxt_cc = cc_ff; // [RULE12]
      endcase
    end
  end

  // Sticky flags: new events are ORed in, clear and initialize ops clear them, env load replaces them
  assign nxt_exc = is_load ? instr_i.image[FSFL_EXC_LSB +: FSFL_EXC_W] :
                   (is_init || is_clr) ? FSFL_EXC_RST :
                   evt ? (exc_ff | instr_i.exc) : exc_ff; // [RULE13] [RULE16]
  assign nxt_sf = is_load ? instr_i.image[FSFL_SF_BIT] :
                  (is_init || is_clr) ? 1'b0 :
                  (sf_ff | fault); // [RULE18] [RULE19] [RULE20]
  assign nxt_mask = is_init ? FSFL_MASK_RST :
                    is_mask ? instr_i.image[5:0] : mask_ff; // [RULE22]
  assign nxt_top = is_init ? FSFL_TOP_RST :
                   v ? instr_i.top : top_ff; // [RULE21]

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      exc_ff <= FSFL_EXC_RST;
      sf_ff <= 1'b0;
      cc_ff <= FSFL_CC_RST;
      top_ff <= FSFL_TOP_RST;
      mask_ff <= FSFL_MASK_RST;
      req_ff <= 1'b0;
    end
    else
    begin
      exc_ff <= nxt_exc;
      sf_ff <= nxt_sf;
      cc_ff <= nxt_cc;
      top_ff <= nxt_top;
      mask_ff <= nxt_mask;
      req_ff <= |(nxt_exc & ~nxt_mask); // [RULE15]
    end
  end

  wire logic [5:0] exc_n = nxt_exc;
  wire logic sf_n = nxt_sf;
  wire logic [3:0] cc_n = nxt_cc;
  wire logic [2:0] top_n = nxt_top;
  wire logic summary_n = |(nxt_exc & ~nxt_mask); // [RULE14]

  // Status word registered from the next-state values, so it matches the flip-flops
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      status_word_o <= 16'h0000;
    else
      status_word_o <= {summary_n, cc_n[3], top_n, cc_n[2], cc_n[1], cc_n[0],
                        summary_n, sf_n, exc_n}; // [RULE14] [RULE17]
  end

  assign fp_exception_o = req_ff;

  // Assertions
  property p_es_mirror;
    @(posedge clk_i) disable iff (!resetn_i)
      status_word_o[FSFL_B_BIT] == status_word_o[FSFL_ES_BIT];
  endproperty
  a_es_mirror: assert property (p_es_mirror) // [RULE17]
    else $error("legacy bit differs from summary");

  property p_summary;
    @(posedge clk_i) disable iff (!resetn_i)
      status_word_o[FSFL_ES_BIT] == summary;
  endproperty
  a_summary: assert property (p_summary) // [RULE14]
    else $error("summary bit not unmasked flags");

  property p_req;
    @(posedge clk_i) disable iff (!resetn_i)
      fp_exception_o == status_word_o[FSFL_ES_BIT];
  endproperty
  a_req: assert property (p_req) // [RULE15]
    else $error("exception request not following summary");

  property p_sticky;
    @(posedge clk_i) disable iff (!resetn_i)
      (exc_ff[0] && !is_load && !is_init && !is_clr) |=> exc_ff[0];
  endproperty
  a_sticky: assert property (p_sticky) // [RULE16]
    else $error("exception flag dropped");

  property p_sf_set;
    @(posedge clk_i) disable iff (!resetn_i)
      fault |=> status_word_o[FSFL_SF_BIT];
  endproperty
  a_sf_set: assert property (p_sf_set) // [RULE18]
    else $error("stack fault flag not set");

  property p_sf_hold;
    @(posedge clk_i) disable iff (!resetn_i)
      (sf_ff && !is_load && !is_init && !is_clr) |=> sf_ff;
  endproperty
  a_sf_hold: assert property (p_sf_hold) // [RULE20]
    else $error("stack fault flag dropped");

  property p_c1_fault;
    @(posedge clk_i) disable iff (!resetn_i)
      (v && op == FSFL_OP_ARITH && fault)
        |=> status_word_o[FSFL_C1_BIT] == $past(instr_i.stack_overflow);
  endproperty
  a_c1_fault: assert property (p_c1_fault) // [RULE1]
    else $error("c1 not showing fault direction");

  property p_prem;
    @(posedge clk_i) disable iff (!resetn_i)
      (v && op == FSFL_OP_PREM)
        |=> cc_ff[2] == $past(instr_i.reduction_incomplete);
  endproperty
  a_prem: assert property (p_prem) // [RULE4]
    else $error("c2 not showing reduction state");

  property p_init;
    @(posedge clk_i) disable iff (!resetn_i)
      is_init |=> (cc_ff == 4'h0 && exc_ff == 6'h00 && !sf_ff);
  endproperty
  a_init: assert property (p_init) // [RULE11]
    else $error("initialize left bits set");

  property p_c1_round;
    @(posedge clk_i) disable iff (!resetn_i)
      (v && op == FSFL_OP_ARITH && !fault && inexact)
        |=> status_word_o[FSFL_C1_BIT] == $past(instr_i.round_up);
  endproperty
  a_c1_round: assert property (p_c1_round) // [RULE2]
    else $error("c1 not showing round-up");

  property p_examine;
    @(posedge clk_i) disable iff (!resetn_i)
      (v && op == FSFL_OP_EXAMINE)
        |=> {status_word_o[FSFL_C3_BIT], status_word_o[FSFL_C2_BIT],
             status_word_o[FSFL_C0_BIT], status_word_o[FSFL_C1_BIT]}
            == $past({instr_i.operand_class, instr_i.sign});
  endproperty
  a_examine: assert property (p_examine) // [RULE3]
    else $error("examine result not in condition bits");

  property p_quotient;
    @(posedge clk_i) disable iff (!resetn_i)
      (v && op == FSFL_OP_PREM && !instr_i.reduction_incomplete)
        |=> {status_word_o[FSFL_C0_BIT], status_word_o[FSFL_C3_BIT],
             status_word_o[FSFL_C1_BIT]} == $past(instr_i.quotient);
  endproperty
  a_quotient: assert property (p_quotient) // [RULE5]
    else $error("quotient bits not in condition bits");

  property p_trig_range;
    @(posedge clk_i) disable iff (!resetn_i)
      (v && op == FSFL_OP_TRIG)
        |=> status_word_o[FSFL_C2_BIT] == $past(instr_i.out_of_range);
  endproperty
  a_trig_range: assert property (p_trig_range) // [RULE6]
    else $error("c2 not showing trig range");

  property p_move_c1;
    @(posedge clk_i) disable iff (!resetn_i)
      (v && op == FSFL_OP_MOVE)
        |=> status_word_o[FSFL_C1_BIT] ==
            $past(instr_i.stack_fault && instr_i.stack_overflow);
  endproperty
  a_move_c1: assert property (p_move_c1) // [RULE10]
    else $error("c1 after move not cleared");

  property p_cmp_un;
    @(posedge clk_i) disable iff (!resetn_i)
      (v && op == FSFL_OP_COMPARE && instr_i.cmp == FSFL_CMP_R_UN)
        |=> status_word_o[FSFL_C3_BIT] && status_word_o[FSFL_C2_BIT] &&
            status_word_o[FSFL_C0_BIT];
  endproperty
  a_cmp_un: assert property (p_cmp_un) // [RULE23]
    else $error("unordered compare not encoded");

  property p_cmp_c1;
    @(posedge clk_i) disable iff (!resetn_i)
      (v && op == FSFL_OP_COMPARE && !instr_i.stack_fault)
        |=> !status_word_o[FSFL_C1_BIT];
  endproperty
  a_cmp_c1: assert property (p_cmp_c1) // [RULE8]
    else $error("c1 after compare not cleared");

  property p_flag_set;
    @(posedge clk_i) disable iff (!resetn_i)
      evt |=> (status_word_o[FSFL_EXC_LSB +: FSFL_EXC_W] &
               $past(instr_i.exc)) == $past(instr_i.exc);
  endproperty
  a_flag_set: assert property (p_flag_set) // [RULE13]
    else $error("detected exception did not set its flag");

  property p_top;
    @(posedge clk_i) disable iff (!resetn_i)
      (v && !is_init)
        |=> status_word_o[FSFL_TOP_LSB +: 3] == $past(instr_i.top);
  endproperty
  a_top: assert property (p_top) // [RULE21]
    else $error("top pointer field wrong");

  property p_init_mask;
    @(posedge clk_i) disable iff (!resetn_i)
      is_init |=> !status_word_o[FSFL_ES_BIT] && !fp_exception_o;
  endproperty
  a_init_mask: assert property (p_init_mask) // [RULE22]
    else $error("summary set with all exceptions masked");

  property p_sf_keep;
    @(posedge clk_i) disable iff (!resetn_i)
      (sf_ff && evt && instr_i.exc[FSFL_IE_IDX] && !instr_i.stack_fault)
        |=> status_word_o[FSFL_SF_BIT];
  endproperty
  a_sf_keep: assert property (p_sf_keep) // [RULE19]
    else $error("invalid operand cleared stack fault");

  property p_load;
    @(posedge clk_i) disable iff (!resetn_i)
      is_load |=> status_word_o[FSFL_C3_BIT] == $past(instr_i.image[14]) &&
                  status_word_o[FSFL_C2_BIT:FSFL_C0_BIT] ==
                  $past(instr_i.image[10:8]);
  endproperty
  a_load: assert property (p_load) // [RULE11]
    else $error("condition bits not loaded from image");

  c_fault: cover property (@(posedge clk_i) disable iff (!resetn_i) fault);
  c_req: cover property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(fp_exception_o));
  c_clr: cover property (@(posedge clk_i) disable iff (!resetn_i)
    sf_ff && is_clr);
  c_prem: cover property (@(posedge clk_i) disable iff (!resetn_i)
    v && op == FSFL_OP_PREM && !instr_i.reduction_incomplete);
  c_load: cover property (@(posedge clk_i) disable iff (!resetn_i)
    is_load);

endmodule // fsfl_status

//--- verif/fpu_status_flag_logic_bench.sv
// Self-checking bench for the status-flag logic
`timescale 1ns/100ps
module fpu_status_flag_logic_bench;
  import fsfl_pkg::*;

  logic clk_i;
  logic resetn_i;
  fsfl_instr_t instr;
  logic [15:0] status_word_o;
  logic fp_exception_o;
  int fails;
  int checks;

  fsfl_status dut_u (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .instr_i(instr),
    .status_word_o(status_word_o),
    .fp_exception_o(fp_exception_o)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  function automatic fsfl_instr_t mk(input fsfl_op_t op);
    mk = '0;
    mk.valid = 1'b1;
    mk.op = op;
    mk.top = 3'h5;
  endfunction

  // Expected status bits for a {c3, c2, c0} code
  function automatic logic [15:0] cc3(input logic [2:0] v);
    cc3 = {1'b0, v[2], 3'b000, v[1], 1'b0, v[0], 8'h00};
  endfunction

  // One instruction, then valid drops so the result can be sampled
  task automatic run(input fsfl_instr_t i);
    @(posedge clk_i);
    #1 instr = i;
    @(posedge clk_i);
    #1 instr.valid = 1'b0;
  endtask

  task automatic chk(input logic [15:0] m, input logic [15:0] e);
    checks++;
    if ((status_word_o & m) !== e)
    begin
      fails++;
      $display("wrong value at %0t: status %h mask %h want %h", $time,
               status_word_o, m, e);
    end
  endtask

  task automatic chkx(input logic e);
    checks++;
    if (fp_exception_o !== e)
    begin
      fails++;
      $display("wrong value at %0t: exception request %b", $time,
               fp_exception_o);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic t_compare();
    fsfl_instr_t i;
    logic [2:0] code [4];
    code = '{FSFL_CMP_GT, FSFL_CMP_LT, FSFL_CMP_EQ, FSFL_CMP_UN};
    for (int k = 0; k < 4; k++)
    begin
      i = mk(FSFL_OP_COMPARE);
      i.cmp = fsfl_cmp_t'(k[1:0]);
      run(i);
      chk(16'h4700, cc3(code[k]));
    end
  endtask

  // Masked faults set flags but never the summary bit
  task automatic t_stack_fault();
    fsfl_instr_t i;
    i = mk(FSFL_OP_ARITH);
    i.exc = 6'h01;
    i.stack_fault = 1'b1;
    i.stack_overflow = 1'b1;
    run(i);
    chk(16'h82FF, 16'h0241);
    chkx(1'b0);
    i.op = FSFL_OP_MOVE;
    i.stack_overflow = 1'b0;
    run(i);
    chk(16'h02FF, 16'h0041);
    i.op = FSFL_OP_ARITH;
    i.stack_fault = 1'b0;
    run(i);
    chk(16'h0040, 16'h0040);
    run(mk(FSFL_OP_CLEAR_EXC));
    chk(16'h80FF, 16'h0000);
  endtask

  task automatic t_round();
    fsfl_instr_t i;
    i = mk(FSFL_OP_ARITH);
    i.exc = 6'h20;
    i.round_up = 1'b1;
    run(i);
    chk(16'h0220, 16'h0220);
    i.round_up = 1'b0;
    run(i);
    chk(16'h0220, 16'h0020);
    i.round_up = 1'b1;
    run(i);
    run(mk(FSFL_OP_MOVE));
    chk(16'h0200, 16'h0000);
  endtask

  task automatic t_class_ops();
    fsfl_instr_t i;
    i = mk(FSFL_OP_EXAMINE);
    i.sign = 1'b1;
    i.operand_class = 3'b101;
    run(i);
    chk(16'h4700, cc3(3'b101) | 16'h0200);
    i = mk(FSFL_OP_PREM);
    i.reduction_incomplete = 1'b1;
    run(i);
    chk(16'h0400, 16'h0400);
    i.reduction_incomplete = 1'b0;
    i.quotient = 3'b110;
    run(i);
    chk(16'h4700, 16'h4100);
    i.quotient = 3'b001;
    run(i);
    chk(16'h4700, 16'h0200);
    i = mk(FSFL_OP_TRIG);
    i.out_of_range = 1'b1;
    run(i);
    chk(16'h0400, 16'h0400);
    i.out_of_range = 1'b0;
    run(i);
    chk(16'h0400, 16'h0000);
  endtask

  // Unmasked invalid flag drives summary, legacy copy and request
  task automatic t_unmasked();
    fsfl_instr_t i;
    // Inexact flag left over from the rounding scenario
    run(mk(FSFL_OP_CLEAR_EXC));
    i = mk(FSFL_OP_SET_MASK);
    i.image = 16'h003E;
    run(i);
    i = mk(FSFL_OP_ARITH);
    i.exc = 6'h01;
    run(i);
    chk(16'h80FF, 16'h8081);
    chkx(1'b1);
    run(mk(FSFL_OP_UNDEF_CC));
    run(mk(FSFL_OP_NONE));
    chk(16'h80FF, 16'h8081);
    run(mk(FSFL_OP_CLEAR_EXC));
    chk(16'h80FF, 16'h0000);
    chkx(1'b0);
  endtask

  task automatic t_env_init();
    fsfl_instr_t i;
    i = mk(FSFL_OP_ENV_LOAD);
    i.image = 16'h4723;
    run(i);
    chk(16'h477F, 16'h4723);
    chk(16'h3800, 16'h2800);
    run(mk(FSFL_OP_INIT));
    chk(16'h47FF, 16'h0000);
    // Initialize also returns the top pointer to register zero
    chk(16'h3800, 16'h0000);
    chkx(1'b0);
  endtask

  initial
  begin
    fails = 0;
    checks = 0;
    resetn_i = 1'b0;
    instr = '0;
    repeat (6) @(posedge clk_i);
    #1 resetn_i = 1'b1;
    chk(16'hFFFF, 16'h0000);
    chkx(1'b0);
    t_compare();
    t_stack_fault();
    t_round();
    t_class_ops();
    t_unmasked();
    t_env_init();
    wrap_up();
  end

  // Whole run is about sixty cycles
  initial
  begin
    #20000;
    fails++;
    wrap_up();
  end

endmodule // fpu_status_flag_logic_bench
